//--- logic/flash_host_regs.svh
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// clock and flash strobe timing
`define CLK_PERIOD_NS  50
`define WE_PULSE_NS    100
`define RD_ACCESS_NS   90
`define SYNC_STAGES    2
`define WE_PULSE_CYC   ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_PULSE_CYC   (((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + `SYNC_STAGES + 1)

// controller register offsets
`define R_CMD          8'h00
`define R_ADDR         8'h04
`define R_WDATA        8'h08
`define R_STATUS       8'h0C
`define R_RDATA        8'h10
`define R_CFG          8'h14

// field positions
`define OP_MSB         3
`define STAT_REFUSED   5
`define CFG_POLL01     0
`define SEC_WORD_MSB   2
`define SEC_HI_MSB     18
`define SEC_HI_LSB     8
`define POLLING_BIT    7
`define TOGGLE_BIT     6
`define FAULT_BIT      5
`define LOCK_FLAG_BIT  1

// flash command addresses and data
`define A_UNLOCK1      19'h0_0555
`define A_UNLOCK2      19'h0_0AAA
`define A_CFI          19'h0_0055
`define A_LOCK         19'h0_0080
`define A_SEC_BASE     19'h0_0081
`define A_SEC_USER     19'h0_0085
`define SEC_USER_WORD  3'h4
`define D_UNLOCK1      16'h00AA
`define D_UNLOCK2      16'h0055
`define D_SEC_CMD      16'h00C0
`define D_ID_ENTRY     16'h0090
`define D_ID_EXIT      16'h00F0
`define D_CFI          16'h0098
`define D_LOCK         16'h0000

`endif

//--- logic/flash_host_pkg.sv
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ        = 4'b0000,
    OP_SEC_READ    = 4'b0001,
    OP_SEC_PROG    = 4'b0010,
    OP_SEC_LOCK    = 4'b0011,
    OP_LOCK_STAT   = 4'b0100,
    OP_ID_ENTRY    = 4'b0101,
    OP_ID_EXIT     = 4'b0110,
    OP_CFI         = 4'b0111,
    OP_TOGGLE_POLL = 4'b1000,
    OP_DATA_POLL   = 4'b1001
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_EVAL  = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    CYC_IDLE  = 2'b00,
    CYC_SETUP = 2'b01,
    CYC_PULSE = 2'b10,
    CYC_HOLD  = 2'b11
  } cyc_state_t;

  typedef struct packed {
    logic        wr;
    logic [18:0] addr;
    logic [15:0] data;
  } bus_req_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } flash_pins_t;

endpackage

//--- logic/bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module bus_cycle (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      start,
  input  wire flash_host_pkg::bus_req_t  req,
  input  wire logic [15:0]               dq_in,
  output logic                           done,
  output logic [15:0]                    rd_data,
  output flash_host_pkg::flash_pins_t    pins
);
  import flash_host_pkg::*;

  localparam flash_pins_t PINS_IDLE = '{addr: '0, dq_o: '0, dq_oe: 1'b0,
                                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
  localparam logic [3:0] WE_LAST = 4'(`WE_PULSE_CYC - 1);
  localparam logic [3:0] RD_LAST = 4'(`RD_PULSE_CYC - 1);

  cyc_state_t  st_q;
  logic [3:0]  cnt_q;
  logic        wr_q;
  logic [15:0] dq_meta_q;
  logic [15:0] dq_sync_q;

  // data pins are asynchronous to CLK
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end else begin
      dq_meta_q <= dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // ce low one cycle before the strobe, data held one cycle after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= CYC_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      done    <= 1'b0;
      rd_data <= '0;
      pins    <= PINS_IDLE;
    end else begin
      done <= 1'b0;
      case (st_q)
        CYC_IDLE: if (start) begin
          wr_q       <= req.wr;
          pins.addr  <= req.addr;
          pins.dq_o  <= req.data;
          pins.dq_oe <= req.wr;
          pins.ce_n  <= 1'b0;
          st_q       <= CYC_SETUP;
        end
        CYC_SETUP: begin
          cnt_q     <= wr_q ? WE_LAST : RD_LAST;
          pins.we_n <= !wr_q;
          pins.oe_n <= wr_q;
          st_q      <= CYC_PULSE;
        end
        CYC_PULSE: if (cnt_q == 4'h0) begin
          pins.we_n <= 1'b1;
          pins.oe_n <= 1'b1;
          if (!wr_q) rd_data <= dq_sync_q;
          st_q <= CYC_HOLD;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
        CYC_HOLD: begin
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
          st_q       <= CYC_IDLE;
        end
        default: st_q <= CYC_IDLE;
      endcase
    end
  end
endmodule

//--- logic/flash_host.sv
// What this block does
// - user half written only by the four-cycle security program sequence.
// - lock sequence drives lock_flag_bit low in the fourth cycle.
// - security register read only after ident_mode_entry.
// - after lock status or security read, only ident_mode_exit or another security read is accepted.
// - single write 98h at 55h enters CFI query mode.
// - CFI mode reads return CFI data; leave only by ident_mode_exit.
// - data polling rechecks polling_bit after seeing fault_bit set.
// - toggle detection rechecks toggle_bit after fault_bit becomes one.
// - security access keeps address 18..8 zero; words 0-3 factory, 4-7 user.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_host (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic [7:0]   REG_ADDR,
  input  wire logic [31:0]  REG_WDATA,
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  output logic [31:0]       REG_RDATA,
  output logic [18:0]       FL_ADDR,
  output logic [15:0]       FL_DQ_O,
  output logic              FL_DQ_OE,
  input  wire logic [15:0]  FL_DQ_I,
  output logic              FL_CE_N,
  output logic              FL_OE_N,
  output logic              FL_WE_N,
  input  wire logic         FL_RDY_I
);
  import flash_host_pkg::*;

  seq_state_t  st_q;
  op_t         op_q;
  logic [1:0]  step_q;
  logic [18:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] prev_q;
  logic        cfg01_q;
  logic        ident_q;
  logic        cfi_q;
  logic        need_exit_q;
  logic        lock_flag_q;
  logic        refused_q;
  logic        fail_q;
  logic        have_prev_q;
  logic        recheck_q;
  logic        rdy_meta_q;
  logic        rdy_sync_q;
  flash_pins_t pins;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  function automatic bus_req_t seq_item(input op_t op, input logic [1:0] step,
                                        input logic [1:0] last, input logic [18:0] sec_a,
                                        input logic [18:0] a, input logic [15:0] d);
    bus_req_t r;
    r = '{wr: 1'b1, addr: `A_UNLOCK1, data: `D_UNLOCK1};
    if (step == 2'd1) r = '{wr: 1'b1, addr: `A_UNLOCK2, data: `D_UNLOCK2};
    if (step == 2'd2) r.data = (op == OP_SEC_PROG || op == OP_SEC_LOCK) ? `D_SEC_CMD
                                                                         : `D_ID_ENTRY;
    if (step == last) begin
      case (op)
        OP_SEC_READ:  r = '{wr: 1'b0, addr: sec_a, data: '0};
        OP_SEC_PROG:  r = '{wr: 1'b1, addr: sec_a, data: d};
        OP_SEC_LOCK:  r = '{wr: 1'b1, addr: `A_LOCK, data: `D_LOCK};
        OP_LOCK_STAT: r = '{wr: 1'b0, addr: `A_LOCK, data: '0};
        OP_ID_ENTRY:  r = '{wr: 1'b1, addr: `A_UNLOCK1, data: `D_ID_ENTRY};
        OP_ID_EXIT:   r = '{wr: 1'b1, addr: `A_UNLOCK1, data: `D_ID_EXIT};
        OP_CFI:       r = '{wr: 1'b1, addr: `A_CFI, data: `D_CFI};
        default:      r = '{wr: 1'b0, addr: a, data: '0};
      endcase
    end
    return r;
  endfunction

  // register port decode
  wire        idle_w     = st_q == ST_IDLE;
  wire        wr_cmd     = REG_WR && REG_ADDR == `R_CMD;
  wire        wr_addr    = REG_WR && REG_ADDR == `R_ADDR && idle_w;
  wire        wr_wdata   = REG_WR && REG_ADDR == `R_WDATA && idle_w;
  wire        wr_cfg     = REG_WR && REG_ADDR == `R_CFG && idle_w;
  wire        wr_status  = REG_WR && REG_ADDR == `R_STATUS;
  wire op_t   new_op     = op_t'(REG_WDATA[`OP_MSB:0]);
  wire        op_known   = REG_WDATA[`OP_MSB:0] <= OP_DATA_POLL;
  wire        exit_block = need_exit_q && new_op != OP_ID_EXIT && new_op != OP_SEC_READ;
  wire        cfi_block  = cfi_q && new_op != OP_READ && new_op != OP_ID_EXIT;
  wire        sec_block  = new_op == OP_SEC_READ && !ident_q;
  wire        user_block = new_op == OP_SEC_PROG &&
                           addr_q[`SEC_WORD_MSB:0] < `SEC_USER_WORD;
  wire        accept     = wr_cmd && idle_w && op_known &&
                           !exit_block && !cfi_block && !sec_block && !user_block;
  wire        refuse_evt = wr_cmd && !accept;

  // sequence step selection
  wire [1:0]     last_step = (op_q == OP_SEC_PROG || op_q == OP_SEC_LOCK ||
                              op_q == OP_LOCK_STAT) ? 2'd3 :
                             (op_q == OP_ID_ENTRY) ? 2'd2 : 2'd0;
  wire [18:0]    sec_addr  = `A_SEC_BASE + 19'(addr_q[`SEC_WORD_MSB:0]);
  wire bus_req_t cyc_req   = seq_item(op_q, step_q, last_step, sec_addr, addr_q, wdata_q);
  wire           cyc_start = st_q == ST_ISSUE;
  wire           is_poll   = op_q == OP_TOGGLE_POLL || op_q == OP_DATA_POLL;
  wire           is_tog    = op_q == OP_TOGGLE_POLL;

  // poll evaluation on the last read
  wire exp_bit   = cfg01_q ? 1'b1 : wdata_q[`POLLING_BIT];
  wire tog_same  = have_prev_q && rdata_q[`TOGGLE_BIT] == prev_q[`TOGGLE_BIT];
  wire compared  = is_tog ? have_prev_q : 1'b1;
  wire pass_w    = is_tog ? tog_same : rdata_q[`POLLING_BIT] == exp_bit;
  wire fail_w    = !pass_w && compared && recheck_q;
  wire recheck_w = !pass_w && compared && !recheck_q && rdata_q[`FAULT_BIT];

  wire [31:0] status_w = {24'h00_0000, rdy_sync_q, fail_q, refused_q, lock_flag_q,
                          need_exit_q, cfi_q, ident_q, !idle_w};
  wire [31:0] rd_sel   = (REG_ADDR == `R_STATUS) ? status_w :
                         (REG_ADDR == `R_RDATA)  ? {16'h0000, rdata_q} :
                         (REG_ADDR == `R_ADDR)   ? {13'h0000, addr_q} :
                         (REG_ADDR == `R_WDATA)  ? {16'h0000, wdata_q} :
                         (REG_ADDR == `R_CFG)    ? {31'h0000_0000, cfg01_q} : 32'h0000_0000;

  bus_cycle u_cycle (
    .clk     (CLK),
    .rst_n   (RST_N),
    .start   (cyc_start),
    .req     (cyc_req),
    .dq_in   (FL_DQ_I),
    .done    (cyc_done),
    .rd_data (cyc_rdata),
    .pins    (pins)
  );

  assign FL_ADDR  = pins.addr;
  assign FL_DQ_O  = pins.dq_o;
  assign FL_DQ_OE = pins.dq_oe;
  assign FL_CE_N  = pins.ce_n;
  assign FL_OE_N  = pins.oe_n;
  assign FL_WE_N  = pins.we_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA  <= 32'h0000_0000;
      addr_q     <= '0;
      wdata_q    <= '0;
      cfg01_q    <= 1'b0;
      refused_q  <= 1'b0;
      rdy_meta_q <= 1'b1;
      rdy_sync_q <= 1'b1;
    end else begin
      REG_RDATA  <= REG_RD ? rd_sel : 32'h0000_0000;
      rdy_meta_q <= FL_RDY_I;
      rdy_sync_q <= rdy_meta_q;
      refused_q  <= refuse_evt | (refused_q & !(wr_status & REG_WDATA[`STAT_REFUSED]));
      if (wr_addr) addr_q <= REG_WDATA[18:0];
      if (wr_wdata) wdata_q <= REG_WDATA[15:0];
      if (wr_cfg) cfg01_q <= REG_WDATA[`CFG_POLL01];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q        <= ST_IDLE;
      op_q        <= OP_READ;
      step_q      <= 2'd0;
      rdata_q     <= '0;
      prev_q      <= '0;
      have_prev_q <= 1'b0;
      recheck_q   <= 1'b0;
      fail_q      <= 1'b0;
      ident_q     <= 1'b0;
      cfi_q       <= 1'b0;
      need_exit_q <= 1'b0;
      lock_flag_q <= 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: if (accept) begin
          op_q        <= new_op;
          step_q      <= 2'd0;
          fail_q      <= 1'b0;
          have_prev_q <= 1'b0;
          recheck_q   <= 1'b0;
          st_q        <= ST_ISSUE;
        end
        ST_ISSUE: st_q <= ST_WAIT;
        ST_WAIT: if (cyc_done) begin
          if (!cyc_req.wr) rdata_q <= cyc_rdata;
          if (step_q != last_step) begin
            step_q <= step_q + 2'd1;
            st_q   <= ST_ISSUE;
          end else if (is_poll) begin
            st_q <= ST_EVAL;
          end else begin
            st_q <= ST_IDLE;
            case (op_q)
              OP_ID_ENTRY: ident_q <= 1'b1;
              OP_LOCK_STAT: begin
                ident_q     <= 1'b1;
                need_exit_q <= 1'b1;
                lock_flag_q <= cyc_rdata[`LOCK_FLAG_BIT];
              end
              OP_SEC_READ: need_exit_q <= 1'b1;
              OP_CFI: cfi_q <= 1'b1;
              OP_ID_EXIT: begin
                ident_q     <= 1'b0;
                cfi_q       <= 1'b0;
                need_exit_q <= 1'b0;
              end
              default: ;
            endcase
          end
        end
        ST_EVAL: if (pass_w || fail_w) begin
          fail_q <= fail_w;
          st_q   <= ST_IDLE;
        end else begin
          prev_q      <= rdata_q;
          have_prev_q <= !recheck_w;
          if (recheck_w) recheck_q <= 1'b1;
          st_q <= ST_ISSUE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_user_prog_final: assert property (
    cyc_start && op_q == OP_SEC_PROG && step_q == 2'd2
      |-> cyc_req.data == `D_SEC_CMD ##[1:30] cyc_start && step_q == 2'd3 &&
          cyc_req.wr && cyc_req.addr >= `A_SEC_USER)
    else $error("user half program not issued as four-cycle sequence");
  chk_lock_bit_low: assert property (
    cyc_start && op_q == OP_SEC_LOCK && step_q == 2'd3
      |-> cyc_req.wr && !cyc_req.data[`LOCK_FLAG_BIT] && cyc_req.addr == `A_LOCK)
    else $error("lock cycle does not drive lock flag bit low");
  chk_sec_read_ident: assert property (
    cyc_start && op_q == OP_SEC_READ |-> ident_q && !cyc_req.wr)
    else $error("security read outside identification mode");
  chk_exit_before_op: assert property (
    accept && need_exit_q |-> new_op inside {OP_ID_EXIT, OP_SEC_READ})
    else $error("operation started before identification exit");
  chk_cfi_entry_cycle: assert property (
    accept && new_op == OP_CFI
      |=> cyc_start && cyc_req.wr && cyc_req.addr == `A_CFI && cyc_req.data == `D_CFI)
    else $error("cfi entry is not one write of 98h at 55h");
  chk_cfi_exit_only: assert property (
    accept && cfi_q |-> new_op inside {OP_READ, OP_ID_EXIT})
    else $error("cfi mode left by other than identification exit");
  chk_data_recheck: assert property (
    $rose(fail_q) && op_q == OP_DATA_POLL |-> $past(recheck_q) && $past(st_q) == ST_EVAL)
    else $error("data poll failed without polling bit recheck");
  chk_toggle_recheck: assert property (
    $rose(fail_q) && op_q == OP_TOGGLE_POLL |-> $past(recheck_q) && $past(have_prev_q))
    else $error("toggle poll failed without toggle bit recheck");
  chk_sec_addr_high: assert property (
    cyc_start && step_q == last_step && op_q inside {OP_SEC_READ, OP_SEC_PROG}
      |-> cyc_req.addr[`SEC_HI_MSB:`SEC_HI_LSB] == '0)
    else $error("security access with upper address bits set");

  cov_user_prog: cover property (cyc_done && op_q == OP_SEC_PROG && step_q == 2'd3);
  cov_cfi_entry: cover property (accept && new_op == OP_CFI && ident_q);
  cov_poll_fail: cover property ($rose(fail_q));
  cov_refused:   cover property (refuse_evt && need_exit_q);
endmodule

//--- bench/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
  parameter int          BUSY_NS = 4000,
  parameter int          POR_NS  = 200,
  parameter logic [15:0] FACTORY = 16'h1000  // arbitrary factory serial base
) (
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_in,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic      [15:0] dq_out,
  output logic             rdy_oe
);
  logic [15:0] sec [0:7];
  logic [1:0]  step;
  logic        id_mode, cfi_mode, locked, busy, fault, tog, por_ok;
  logic [15:0] pd, rd_val;
  wire  [18:0] sec_off = addr - 19'h0_0081;
  wire         sec_hit = (addr[18:8] == 11'h000) && (addr[7:0] >= 8'h81) && (addr[7:0] <= 8'h88);

  initial begin
    for (int w = 0; w < 8; w++) sec[w] = (w < 4) ? FACTORY + 16'(w) : 16'hFFFF;
    {step, id_mode, cfi_mode, locked, busy, fault, tog, por_ok} = '0;
    pd = 16'h0000;
    #POR_NS por_ok = 1'b1;
  end

  // commands latch on the rising write strobe only
  always @(posedge we_n) begin
    if (!ce_n && oe_n) begin
      if (step == 2'd3) begin
        step = 2'd0;
        if (addr == 19'h0_0080) begin
          locked = locked | ~dq_in[1];
        end else if (!por_ok) begin
          step = 2'd0;
        end else if (locked || !sec_hit || sec_off < 19'h0_0004) begin
          // polling shows the complement of bit 7 of the refused word as well
          pd = dq_in;
          fault = 1'b1;
        end else begin
          sec[sec_off[2:0]] = dq_in;
          pd = dq_in;
          busy = 1'b1;
        end
      end else if (dq_in[7:0] == 8'hF0) begin
        {id_mode, cfi_mode, fault, step} = '0;
      end else if (step == 2'd0 && addr[7:0] == 8'h55 && dq_in[7:0] == 8'h98) begin
        cfi_mode = 1'b1;
      end else if (step == 2'd0 && addr[11:0] == 12'h555 && dq_in[7:0] == 8'hAA) begin
        step = 2'd1;
      end else if (step == 2'd1 && addr[11:0] == 12'hAAA && dq_in[7:0] == 8'h55) begin
        step = 2'd2;
      end else if (step == 2'd2 && addr[11:0] == 12'h555 && dq_in[7:0] == 8'h90) begin
        id_mode = 1'b1;
        step = 2'd0;
      end else if (step == 2'd2 && addr[11:0] == 12'h555 && dq_in[7:0] == 8'hC0) begin
        step = 2'd3;
      end else begin
        step = 2'd0;
      end
    end
  end

  always @(posedge busy) begin
    #BUSY_NS;
    busy = 1'b0;
  end

  always @(negedge oe_n) begin
    if (!ce_n && (busy || fault)) tog = ~tog;
  end

  always_comb begin
    if (busy || fault) rd_val = {8'h00, ~pd[7], tog, fault, 5'h00};
    else if (cfi_mode) rd_val = {8'h51, addr[7:0]};
    else if (id_mode && addr == 19'h0_0080) rd_val = {14'h0000, ~locked, 1'b0};
    else if (id_mode && sec_hit) rd_val = sec[sec_off[2:0]];
    else if (id_mode) rd_val = 16'h0000;
    else rd_val = addr[15:0] ^ 16'hA5C3;
  end

  // released bus shows the inverse so a stale sample cannot match
  assign dq_out = (!ce_n && !oe_n) ? rd_val : ~rd_val;
  assign rdy_oe = busy;
endmodule

//--- bench/test_flash_host.sv
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module test_flash_host;
  import flash_host_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, rdy_oe;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [18:0] fl_addr, ca;
  logic [15:0] fl_dq_o, dev_dq, pd;
  logic [15:0] shadow [0:7];
  int          num_errors, check_count, seed;
  wire  [15:0] dq_bus = fl_dq_oe ? fl_dq_o : dev_dq;
  wire         rdy_line = ~rdy_oe;  // pull-up, device only pulls low

  flash_host DUT (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FL_ADDR(fl_addr),
    .FL_DQ_O(fl_dq_o), .FL_DQ_OE(fl_dq_oe), .FL_DQ_I(dq_bus), .FL_CE_N(fl_ce_n),
    .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .FL_RDY_I(rdy_line));
  flash_device_model flash_dev (.addr(fl_addr), .dq_in(dq_bus), .ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n), .dq_out(dev_dq), .rdy_oe(rdy_oe));

  always #25 clk = ~clk;

  function automatic logic [15:0] arr(input logic [18:0] a);
    return a[15:0] ^ 16'hA5C3;
  endfunction

  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    rd(`R_STATUS);
    chk(rv & mask, exp);
  endtask

  task automatic op(input op_t o);
    wr(`R_CMD, {28'h000_0000, o});
    for (int i = 0; i < 600; i++) begin
      rd(`R_STATUS);
      if (rv[0] === 1'b0) return;
    end
    num_errors++;
    finish_test();
  endtask

  task automatic sec_check(input int w);
    wr(`R_ADDR, 32'(w));
    op(OP_SEC_READ);
    rd(`R_RDATA);
    chk(rv, {16'h0000, shadow[w]});
  endtask

  initial begin
    seed = 32'h5184_14b6;
    {clk, rst_n, reg_wr, reg_rd} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    for (int w = 0; w < 8; w++) shadow[w] = (w < 4) ? 16'h1000 + 16'(w) : 16'hFFFF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`R_CFG);
    chk(rv, 32'h0000_0000);
    st(32'h0000_00FF, 32'h0000_0090);
    rd(8'hFC);
    chk(rv, 32'h0000_0000);
    wr(`R_CFG, 32'h0000_0001);
    rd(`R_CFG);
    chk(rv, 32'h0000_0001);
    wr(`R_CFG, 32'h0000_0000);
    // security read without identification mode
    op(OP_SEC_READ);
    st(32'h0000_0020, 32'h0000_0020);
    wr(`R_STATUS, 32'h0000_0020);
    st(32'h0000_0020, 32'h0000_0000);
    // program the user half with random words, toggle polling each
    for (int w = 4; w < 8; w++) begin
      pd = 16'($random(seed));
      shadow[w] = pd;
      wr(`R_ADDR, 32'(w));
      wr(`R_WDATA, {16'h0000, pd});
      op(OP_SEC_PROG);
      st(32'h0000_0080, 32'h0000_0000);
      op(OP_TOGGLE_POLL);
      st(32'h0000_00C0, 32'h0000_0080);
    end
    // data polling: loaded bit7 equals the true word at that address
    pd = 16'($random(seed));
    rv = {16'h0000, arr(19'h0_0006)};
    pd[7] = rv[7];
    shadow[6] = pd;
    wr(`R_WDATA, {16'h0000, pd});
    wr(`R_ADDR, 32'h0000_0006);
    op(OP_SEC_PROG);
    op(OP_DATA_POLL);
    st(32'h0000_00C0, 32'h0000_0080);
    // factory half is never programmable
    wr(`R_ADDR, 32'h0000_0001);
    op(OP_SEC_PROG);
    st(32'h0000_0020, 32'h0000_0020);
    wr(`R_STATUS, 32'h0000_0020);
    op(OP_ID_ENTRY);
    st(32'h0000_0002, 32'h0000_0002);
    for (int w = 0; w < 8; w++) sec_check(w);
    op(OP_READ);
    st(32'h0000_0028, 32'h0000_0028);
    wr(`R_STATUS, 32'h0000_0020);
    op(OP_ID_EXIT);
    st(32'h0000_000E, 32'h0000_0000);
    // lock the user half
    op(OP_LOCK_STAT);
    st(32'h0000_0010, 32'h0000_0010);
    op(OP_ID_EXIT);
    op(OP_SEC_LOCK);
    op(OP_LOCK_STAT);
    st(32'h0000_0010, 32'h0000_0000);
    op(OP_ID_EXIT);
    // program into locked half: fault bit, both polls must fail
    pd = 16'($random(seed));
    wr(`R_WDATA, {16'h0000, pd});
    wr(`R_ADDR, 32'h0000_0005);
    op(OP_SEC_PROG);
    wr(`R_ADDR, 32'h0000_0085);
    op(OP_DATA_POLL);
    st(32'h0000_0040, 32'h0000_0040);
    op(OP_TOGGLE_POLL);
    st(32'h0000_0040, 32'h0000_0040);
    op(OP_ID_EXIT);
    op(OP_ID_ENTRY);
    sec_check(5);
    op(OP_ID_EXIT);
    // query mode from read state, then from identification mode
    for (int k = 0; k < 2; k++) begin
      if (k == 1) op(OP_ID_ENTRY);
      op(OP_CFI);
      st(32'h0000_0004, 32'h0000_0004);
      ca = 19'($random(seed));
      wr(`R_ADDR, {13'h0000, ca});
      op(OP_READ);
      rd(`R_RDATA);
      chk(rv, {16'h0000, 8'h51, ca[7:0]});
      op(OP_SEC_LOCK);
      st(32'h0000_0024, 32'h0000_0024);
      wr(`R_STATUS, 32'h0000_0020);
      op(OP_ID_EXIT);
      st(32'h0000_0006, 32'h0000_0000);
    end
    finish_test();
  end
endmodule
